// ==== pkg/lsdt_pkg.sv ====
// lsdt_pkg: constants, line-state codes and helpers of the line-state duration timers
// assumes a 100 MHz core clock and a byte-wide control bus with 5-bit register addresses
package lsdt_pkg;

    // clock and step timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_PERIOD_NS = 80;
    localparam int STEP_CYCLES = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] STEP_LAST = 3'(STEP_CYCLES - 1);
    localparam logic [2:0] STEP_RESET = 3'h0;

    // register offsets
    localparam logic [4:0] ADDR_NOISE_COUNT_SNAPSHOT = 5'h0F;
    localparam logic [4:0] ADDR_NOISE_PRESCALE_COUNT_SNAPSHOT = 5'h10;
    localparam logic [4:0] ADDR_LINE_STATE_DURATION_THRESHOLD = 5'h11;
    localparam logic [4:0] ADDR_LINE_STATE_PRESCALE_THRESHOLD = 5'h12;
    localparam logic [4:0] ADDR_LINE_STATE_COUNT_SNAPSHOT = 5'h13;
    localparam logic [4:0] ADDR_LINE_STATE_PRESCALE_COUNT_SNAPSHOT = 5'h14;

    // field layout
    localparam int COUNT_WIDTH = 7;
    localparam int PRESCALE_WIDTH = 8;
    localparam int CHANGE_DETECT_BIT = 7;

    // values after reset and of unmapped reads
    localparam logic [6:0] DURATION_THRESHOLD_RESET = 7'h00;
    localparam logic [7:0] PRESCALE_THRESHOLD_RESET = 8'h00;
    localparam logic [6:0] TIMER_COUNT_RESET = 7'h00;
    localparam logic [7:0] TIMER_PRESCALE_RESET = 8'h00;
    localparam logic [7:0] READ_DATA_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // received line state codes
    typedef enum logic [2:0] {
        LS_ALS = 3'b000,
        LS_NLS = 3'b001,
        LS_LSU = 3'b010,
        LS_HLS = 3'b011,
        LS_ILS = 3'b100,
        LS_MLS = 3'b101,
        LS_QLS = 3'b110,
        LS_NSD = 3'b111
    } lsdt_line_state_type;

    localparam lsdt_line_state_type LINE_STATE_RESET = LS_LSU;

    // line states in which the duration timers run
    function automatic logic isDurationState(input lsdt_line_state_type ls);
        return (ls == LS_HLS) || (ls == LS_ILS) || (ls == LS_MLS) || (ls == LS_QLS) || (ls == LS_NSD);
    endfunction : isDurationState

    // line states in which the noise timers run
    function automatic logic isNoiseState(input lsdt_line_state_type ls);
        return (ls == LS_NLS) || (ls == LS_ALS) || (ls == LS_LSU);
    endfunction : isNoiseState

endpackage : lsdt_pkg

// ==== hw/lsdt_timer_pair.sv ====
// lsdt_timer_pair: a 7-bit timer stepped by an 8-bit prescale down-counter
// assumes step is a one-cycle pulse every 80 ns and reload a pulse or a held level on the same clock
`timescale 1ns/1ns
`default_nettype none
module lsdt_timer_pair
    import lsdt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic step,
    input wire logic countEn,
    input wire logic reload,
    input wire logic [6:0] threshold,
    input wire logic [7:0] prescaleThreshold,
    output logic [6:0] count,
    output logic [7:0] prescale,
    output logic expired
);

    typedef struct packed {
        logic [6:0] count;
        logic [7:0] prescale;
        logic expired;
    } lsdt_timer_state_type;

    lsdt_timer_state_type q;
    lsdt_timer_state_type d;

    always_comb begin
        d = q;
        d.expired = 1'b0;
        if (reload) begin
            // load both from thresholds together
            d.count = threshold; // R08 R09
            d.prescale = prescaleThreshold;
        end else if (step && countEn) begin
            if (q.count == 7'h00 && q.prescale == 8'h00) begin
                d.count = threshold; // R07
                d.prescale = prescaleThreshold;
            end else if (q.prescale == 8'h00) begin
                d.prescale = prescaleThreshold; // R10
                d.count = q.count - 7'h01; // R05 R06 R18
            end else begin
                d.prescale = q.prescale - 8'h01; // R12
            end
            // flag only the step that lands on both zero
            d.expired = (d.count == 7'h00) && (d.prescale == 8'h00)
                && !(q.count == 7'h00 && q.prescale == 8'h00); // R19
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q.count <= TIMER_COUNT_RESET;
            q.prescale <= TIMER_PRESCALE_RESET;
            q.expired <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign count = q.count;
    assign prescale = q.prescale;
    assign expired = q.expired;

endmodule : lsdt_timer_pair
`default_nettype wire

// ==== hw/lsdt_line_state_timers.sv ====
// lsdt_line_state_timers: line-state duration timer, noise timer and their control-bus registers
// assumes the control bus request and the line-state code arrive on clk from same-clock logic,
// and that the noise threshold registers live in a neighbouring block that pulses a write strobe
//
// How it works
// R01: noise count snapshot read captures 7-bit noise count
// R02: snapshot write discarded, reject flag set
// R03: noise snapshot bit 7 shows change detection
// R04: noise prescale snapshot read captures prescale count
// R05: state timer steps when prescale zero, qualifying
// R06: expiry after ((P+1)*S+P) steps of 80 ns
// R07: both zero and qualifying reloads both timers
// R08: change into qualifying state reloads both timers
// R09: threshold register write reloads both timers
// R10: prescale timer reloads from threshold at zero
// R11: ALS, NLS, LSU hold the timers still
// R12: prescale timer steps every 80 ns qualifying
// R13: duration threshold is 7 bits, bit 7 zero
// R14: prescale threshold holds a full 8 bits
// R15: state count snapshot read captures 7-bit count
// R16: state snapshot bit 7 shows change detection
// R17: state prescale snapshot read captures prescale count
// R18: noise timer steps every 80*(prescale threshold+1) ns
// R19: both timers zero raises the state-threshold flag
`timescale 1ns/1ns
`default_nettype none
module lsdt_line_state_timers
    import lsdt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic cbStrobe,
    input wire logic cbWrite,
    input wire logic [4:0] cbAddr,
    input wire logic [7:0] cbWrData,
    output logic [7:0] cbRdData,
    output logic cbAck,
    input wire logic [2:0] lineState,
    input wire logic [6:0] noiseThreshold,
    input wire logic [7:0] noisePrescaleThreshold,
    input wire logic noiseThresholdWrite,
    output logic writeRejectSet,
    output logic stateThresholdSet,
    output logic noiseThresholdSet
);

    typedef struct packed {
        logic [2:0] stepTick;
        logic [6:0] durationThreshold;
        logic [7:0] prescaleThreshold;
        lsdt_line_state_type lineStatePrev;
        logic durationChange;
        logic noiseChange;
        logic thresholdWrite;
        logic [7:0] rdData;
        logic ack;
        logic writeReject;
    } lsdt_regs_type;

    lsdt_regs_type q;
    lsdt_regs_type d;

    lsdt_line_state_type lineStateNow;
    logic stepPulse;
    logic lineStateChanged;
    logic durationQualify;
    logic noiseQualify;
    logic durationReload;
    logic noiseReload;
    logic readReq;
    logic writeReq;
    logic [6:0] durationCount;
    logic [7:0] durationPrescale;
    logic [6:0] noiseCount;
    logic [7:0] noisePrescale;

    // line-state decode
    assign lineStateNow = lsdt_line_state_type'(lineState);
    assign durationQualify = isDurationState(lineStateNow);
    assign noiseQualify = isNoiseState(lineStateNow);
    assign lineStateChanged = (lineStateNow != q.lineStatePrev);

    // 80 ns step from the core clock
    assign stepPulse = (q.stepTick == STEP_LAST);

    // timer reload requests
    assign durationReload = q.thresholdWrite || (lineStateChanged && durationQualify); // R08 R09
    assign noiseReload = durationQualify || noiseThresholdWrite;

    // bus request decode
    assign readReq = cbStrobe && !cbWrite;
    assign writeReq = cbStrobe && cbWrite;

    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.writeReject = 1'b0;
        d.thresholdWrite = 1'b0;
        d.lineStatePrev = lineStateNow;

        // free-running step divider
        if (stepPulse) begin
            d.stepTick = STEP_RESET;
        end else begin
            d.stepTick = q.stepTick + 3'h1;
        end

        // register reads: snapshots are taken here
        if (readReq) begin
            d.ack = 1'b1;
            case (cbAddr)
                ADDR_NOISE_COUNT_SNAPSHOT: begin
                    d.rdData = {q.noiseChange, noiseCount}; // R01 R03
                    d.noiseChange = 1'b0;
                end
                ADDR_NOISE_PRESCALE_COUNT_SNAPSHOT: begin
                    d.rdData = noisePrescale; // R04
                end
                ADDR_LINE_STATE_DURATION_THRESHOLD: begin
                    d.rdData = {1'b0, q.durationThreshold}; // R13
                end
                ADDR_LINE_STATE_PRESCALE_THRESHOLD: begin
                    d.rdData = q.prescaleThreshold; // R14
                end
                ADDR_LINE_STATE_COUNT_SNAPSHOT: begin
                    d.rdData = {q.durationChange, durationCount}; // R15 R16
                    d.durationChange = 1'b0;
                end
                ADDR_LINE_STATE_PRESCALE_COUNT_SNAPSHOT: begin
                    d.rdData = durationPrescale; // R17
                end
                default: begin
                    d.rdData = UNMAPPED_READ_VALUE;
                end
            endcase
        end

        // register writes
        if (writeReq) begin
            d.ack = 1'b1;
            case (cbAddr)
                ADDR_LINE_STATE_DURATION_THRESHOLD: begin
                    d.durationThreshold = cbWrData[6:0]; // R13
                    d.thresholdWrite = 1'b1; // R09
                end
                ADDR_LINE_STATE_PRESCALE_THRESHOLD: begin
                    d.prescaleThreshold = cbWrData; // R14
                    d.thresholdWrite = 1'b1; // R09
                end
                ADDR_NOISE_COUNT_SNAPSHOT,
                ADDR_NOISE_PRESCALE_COUNT_SNAPSHOT,
                ADDR_LINE_STATE_COUNT_SNAPSHOT,
                ADDR_LINE_STATE_PRESCALE_COUNT_SNAPSHOT: begin
                    d.writeReject = 1'b1; // R02
                end
                default: begin
                    d.writeReject = 1'b0;
                end
            endcase
        end

        // change detection: a new change wins over a clearing read
        if (lineStateChanged && durationQualify) begin
            d.durationChange = 1'b1; // R16
        end
        if (lineStateChanged && noiseQualify) begin
            d.noiseChange = 1'b1; // R03
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q.stepTick <= STEP_RESET;
            q.durationThreshold <= DURATION_THRESHOLD_RESET;
            q.prescaleThreshold <= PRESCALE_THRESHOLD_RESET;
            q.lineStatePrev <= LINE_STATE_RESET;
            q.durationChange <= 1'b0;
            q.noiseChange <= 1'b0;
            q.thresholdWrite <= 1'b0;
            q.rdData <= READ_DATA_RESET;
            q.ack <= 1'b0;
            q.writeReject <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // line-state duration timer: holds in ALS, NLS, LSU
    lsdt_timer_pair durationTimer (
        .clk(clk),
        .resetn(resetn),
        .step(stepPulse),
        .countEn(durationQualify), // R11
        .reload(durationReload),
        .threshold(q.durationThreshold),
        .prescaleThreshold(q.prescaleThreshold),
        .count(durationCount),
        .prescale(durationPrescale),
        .expired(stateThresholdSet)
    );

    // noise timer: runs in NLS, ALS, LSU, held loaded otherwise
    lsdt_timer_pair noiseTimer (
        .clk(clk),
        .resetn(resetn),
        .step(stepPulse),
        .countEn(noiseQualify), // R18
        .reload(noiseReload),
        .threshold(noiseThreshold),
        .prescaleThreshold(noisePrescaleThreshold),
        .count(noiseCount),
        .prescale(noisePrescale),
        .expired(noiseThresholdSet)
    );

    assign cbRdData = q.rdData;
    assign cbAck = q.ack;
    assign writeRejectSet = q.writeReject;

endmodule : lsdt_line_state_timers
`default_nettype wire

// ==== tb/lsdt_line_state_timers_asserts.sv ====
// checker: port assertions of the line-state duration timers
// assumes it sees only the top module's ports, bound below
`timescale 1ns/1ns
`default_nettype none
module lsdt_line_state_timers_asserts
    import lsdt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic cbStrobe,
    input wire logic cbWrite,
    input wire logic [4:0] cbAddr,
    input wire logic [7:0] cbWrData,
    input wire logic [7:0] cbRdData,
    input wire logic cbAck,
    input wire logic [2:0] lineState,
    input wire logic [6:0] noiseThreshold,
    input wire logic [7:0] noisePrescaleThreshold,
    input wire logic noiseThresholdWrite,
    input wire logic writeRejectSet,
    input wire logic stateThresholdSet,
    input wire logic noiseThresholdSet
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic snapWr;
    assign snapWr = cbStrobe && cbWrite && (cbAddr inside {5'h0F, 5'h10, 5'h13, 5'h14});
    ack_follows_req_a:
        assert property (cbStrobe |=> cbAck) else $error("ack missing");
    ack_only_req_a:
        assert property (!cbStrobe |=> !cbAck) else $error("stray ack");
    reject_on_snap_a:
        assert property (snapWr |=> writeRejectSet && cbAck) else $error("reject missing");
    no_stray_reject_a:
        assert property (!snapWr |=> !writeRejectSet) else $error("stray reject");
    thr_bit_seven_a:
        assert property (cbStrobe && !cbWrite && cbAddr == 5'h11 |=> !cbRdData[7]) else $error("bit 7 set");
    rd_data_hold_a:
        assert property (!cbStrobe || cbWrite |=> $stable(cbRdData)) else $error("read data moved");
    state_flag_gap_a:
        assert property (stateThresholdSet |=> !stateThresholdSet [*7]) else $error("flag too soon");
    state_hold_a:
        assert property (!isDurationState(lsdt_line_state_type'(lineState)) |=> !stateThresholdSet)
            else $error("flag while held");
    noise_hold_a:
        assert property (isDurationState(lsdt_line_state_type'(lineState)) |=> !noiseThresholdSet)
            else $error("noise flag in duration state");
endmodule : lsdt_line_state_timers_asserts
bind lsdt_line_state_timers lsdt_line_state_timers_asserts lsdt_line_state_timers_asserts_inst (
    .clk(clk), .resetn(resetn), .cbStrobe(cbStrobe), .cbWrite(cbWrite), .cbAddr(cbAddr),
    .cbWrData(cbWrData), .cbRdData(cbRdData), .cbAck(cbAck), .lineState(lineState),
    .noiseThreshold(noiseThreshold), .noisePrescaleThreshold(noisePrescaleThreshold),
    .noiseThresholdWrite(noiseThresholdWrite), .writeRejectSet(writeRejectSet),
    .stateThresholdSet(stateThresholdSet), .noiseThresholdSet(noiseThresholdSet)
);
`default_nettype wire

// ==== tb/lsdt_host.sv ====
// lsdt_host: management host model issuing control-bus accesses
// assumes one-cycle request pulses and a one-cycle ack on the next cycle
`timescale 1ns/1ns
`default_nettype none
module lsdt_host
    import lsdt_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] cbRdData,
    input wire logic cbAck,
    input wire logic writeRejectSet,
    output logic cbStrobe,
    output logic cbWrite,
    output logic [4:0] cbAddr,
    output logic [7:0] cbWrData
);
    initial begin
        cbStrobe = 1'b0;
        cbWrite = 1'b0;
        cbAddr = 5'h00;
        cbWrData = 8'h00;
    end
    // request for its taking edge, answer sampled at the next edge
    task automatic access(input logic wr, input logic [4:0] addr, input logic [7:0] data,
                          output logic [7:0] rd, output logic rej, output logic ack);
        @(posedge clk);
        cbStrobe <= 1'b1;
        cbWrite <= wr;
        cbAddr <= addr;
        cbWrData <= data;
        @(posedge clk);
        cbStrobe <= 1'b0;
        cbAddr <= ~addr;
        cbWrData <= ~data;
        @(posedge clk);
        rd = cbRdData;
        rej = writeRejectSet;
        ack = cbAck;
    endtask : access
endmodule : lsdt_host
`default_nettype wire

// ==== tb/tb_line_state_duration_timers.sv ====
// tb_line_state_duration_timers: self-checking bench of the line-state duration timers
// assumes the host model drives the control bus and the bench drives line state
`timescale 1ns/1ns
`default_nettype none
module tb_line_state_duration_timers
    import lsdt_pkg::*;
;
    logic clk = 1'b0;
    logic resetn, noiseThresholdWrite, cbStrobe, cbWrite, cbAck, rej, ack;
    logic writeRejectSet, stateThresholdSet, noiseThresholdSet;
    logic [2:0] lineState;
    logic [4:0] cbAddr;
    logic [6:0] noiseThreshold, s;
    logic [7:0] noisePrescaleThreshold, cbWrData, cbRdData, rd, prev, p;
    logic [31:0] seed = 32'h8B0BBEF0;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    lsdt_line_state_type durStates[5] = '{LS_HLS, LS_ILS, LS_MLS, LS_QLS, LS_NSD};
    lsdt_line_state_type idleStates[3] = '{LS_ALS, LS_NLS, LS_LSU};
    logic [4:0] snapAddr[4] = '{5'h0F, 5'h10, 5'h13, 5'h14};
    lsdt_line_state_timers lsdt_line_state_timers_inst (
        .clk(clk), .resetn(resetn), .cbStrobe(cbStrobe), .cbWrite(cbWrite), .cbAddr(cbAddr),
        .cbWrData(cbWrData), .cbRdData(cbRdData), .cbAck(cbAck), .lineState(lineState),
        .noiseThreshold(noiseThreshold), .noisePrescaleThreshold(noisePrescaleThreshold),
        .noiseThresholdWrite(noiseThresholdWrite), .writeRejectSet(writeRejectSet),
        .stateThresholdSet(stateThresholdSet), .noiseThresholdSet(noiseThresholdSet)
    );
    lsdt_host lsdt_host_inst (
        .clk(clk), .cbRdData(cbRdData), .cbAck(cbAck), .writeRejectSet(writeRejectSet),
        .cbStrobe(cbStrobe), .cbWrite(cbWrite), .cbAddr(cbAddr), .cbWrData(cbWrData)
    );
    always #5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr
    // cycles between two expiry pulses
    function automatic int period(input int thr, input int pre);
        return ((pre + 1) * thr + pre + 1) * STEP_CYCLES;
    endfunction : period
    task automatic finish_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            $display("FAIL %0t got %0h exp %0h", $time, got, exp);
            fail_count++;
        end
    endtask : check
    task automatic acc(input logic wr, input logic [4:0] addr, input logic [7:0] data);
        lsdt_host_inst.access(wr, addr, data, rd, rej, ack);
        check({15'h0000, ack}, 16'h0001);
    endtask : acc
    task automatic rdChk(input logic [4:0] addr, input logic [7:0] exp);
        acc(1'b0, addr, 8'h00);
        check({8'h00, rd}, {8'h00, exp});
    endtask : rdChk
    task automatic flagGap(input logic noise);
        int k;
        k = 0;
        n = 0;
        while ((noise ? noiseThresholdSet : stateThresholdSet) !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        do begin
            @(posedge clk);
            n++;
        end while ((noise ? noiseThresholdSet : stateThresholdSet) !== 1'b1 && n < 3000);
    endtask : flagGap
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        resetn = 1'b0;
        lineState = LS_LSU;
        noiseThreshold = 7'h00;
        noisePrescaleThreshold = 8'h00;
        noiseThresholdWrite = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rdChk(5'h11, 8'h00);
        rdChk(5'h12, 8'h00);
        rdChk(5'h1F, 8'h00);
        foreach (snapAddr[i]) begin
            acc(1'b1, snapAddr[i], 8'hA5);
            check({15'h0000, rej}, 16'h0001);
        end
        rdChk(5'h13, 8'h00);
        acc(1'b1, 5'h1F, 8'h5A);
        check({15'h0000, rej}, 16'h0000);
        foreach (durStates[i]) begin
            seed = lfsr(seed);
            s = {5'h00, seed[1:0]};
            p = {6'h00, seed[3:2]} + 8'h01;
            acc(1'b1, 5'h11, {1'b1, s});
            check({15'h0000, rej}, 16'h0000);
            rdChk(5'h11, {1'b0, s});
            acc(1'b1, 5'h12, p);
            rdChk(5'h12, p);
            lineState <= durStates[i];
            rdChk(5'h13, {1'b1, s});
            acc(1'b0, 5'h14, 8'h00);
            check({15'h0000, rd == p || rd == p - 8'h01}, 16'h0001);
            acc(1'b0, 5'h13, 8'h00);
            check({15'h0000, rd[7]}, 16'h0000);
            flagGap(1'b0);
            check(16'(n), 16'(period(s, p)));
        end
        foreach (idleStates[i]) begin
            lineState <= idleStates[i];
            acc(1'b0, 5'h14, 8'h00);
            prev = rd;
            repeat (40) @(posedge clk);
            rdChk(5'h14, prev);
        end
        // corner: zero prescale threshold, written while the timers hold
        acc(1'b1, 5'h12, 8'h00);
        acc(1'b1, 5'h11, 8'h03);
        rdChk(5'h13, 8'h03);
        rdChk(5'h14, 8'h00);
        lineState <= LS_HLS;
        flagGap(1'b0);
        check(16'(n), 16'(period(3, 0)));
        seed = lfsr(seed);
        noiseThreshold <= {5'h00, seed[5:4]};
        noisePrescaleThreshold <= {6'h00, seed[7:6]} + 8'h01;
        lineState <= LS_QLS;
        acc(1'b0, 5'h0F, 8'h00);
        check({9'h000, rd[6:0]}, {9'h000, noiseThreshold});
        rdChk(5'h10, noisePrescaleThreshold);
        lineState <= LS_NLS;
        noiseThresholdWrite <= 1'b1;
        @(posedge clk);
        noiseThresholdWrite <= 1'b0;
        acc(1'b0, 5'h0F, 8'h00);
        check({15'h0000, rd[7]}, 16'h0001);
        flagGap(1'b1);
        check(16'(n), 16'(period(noiseThreshold, noisePrescaleThreshold)));
        // second reset in mid-run: thresholds and counters back to zero
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rdChk(5'h12, 8'h00);
        rdChk(5'h13, 8'h00);
        finish_test();
    end
endmodule : tb_line_state_duration_timers
`default_nettype wire
